/* File: common/bidc_pkg.sv */
/*
  Shared constants for the byte instruction decode core: quarter timing,
  opcode slices, register offsets, field positions and reset values.
  Assumes it is compiled before every rtl/ file.
*/
package bidc_pkg;
  // Widths
  localparam int unsigned PC_W    = 20;
  localparam int unsigned DADDR_W = 12;
  localparam int unsigned PTR_W   = 12;
  localparam int unsigned BUS_AW  = 8;
  localparam int unsigned PTR_N   = 3;

  // Quarter counter: one instruction cycle is four oscillator periods
  localparam logic [1:0] Q_DECODE = 2'h0;
  localparam logic [1:0] Q_READ   = 2'h1;
  localparam logic [1:0] Q_LAST   = 2'h3;
  localparam logic [1:0] Q_STEP   = 2'h1;

  // Opcode slices
  localparam logic [15:0] OP_DAW     = 16'h0007;
  localparam logic [5:0]  OP_DEC6    = 6'h01;
  localparam logic [14:0] OP_RET15   = 15'h0009;
  localparam logic [12:0] OP_TBL13   = 13'h0001;
  localparam logic [7:0]  OP_MOVL8   = 8'h0E;
  localparam logic [3:0]  OP_BSET4   = 4'h8;
  localparam logic [3:0]  OP_BCLR4   = 4'h9;
  localparam logic [3:0]  OP_BTST4   = 4'hB;
  localparam logic [7:0]  OP_GOTO8   = 8'hEF;
  localparam logic [6:0]  OP_CALL7   = 7'h76;
  localparam logic [9:0]  OP_LPTR10  = 10'h3B8;
  localparam logic [3:0]  SECOND_NIB = 4'hF;

  // Field positions
  localparam int unsigned F_D     = 9;
  localparam int unsigned F_A     = 8;
  localparam int unsigned F_B_LO  = 9;
  localparam int unsigned F_S     = 0;
  localparam int unsigned F_TBLWR = 2;
  localparam int unsigned F_CALLS = 8;

  // Flag positions in the status register
  localparam int unsigned ST_C  = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z  = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N  = 4;

  // Control register bits
  localparam int unsigned CTL_RUN  = 0;
  localparam int unsigned CTL_STEP = 1;

  localparam logic [3:0] ACCESS_BANK = 4'h0;

  // Register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WORK   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BANK   = 8'h0C;
  localparam logic [7:0] REG_PC     = 8'h10;
  localparam logic [7:0] REG_PTR0   = 8'h14;
  localparam logic [7:0] REG_PTR1   = 8'h18;
  localparam logic [7:0] REG_PTR2   = 8'h1C;
  localparam logic [7:0] REG_RETPC  = 8'h20;
  localparam logic [7:0] REG_CYCLES = 8'h24;
  localparam logic [7:0] REG_INSTR  = 8'h28;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST  = 20'h00000;
  localparam logic [15:0]     IR_RST  = 16'h0000;
  localparam logic            RUN_RST = 1'b0;

  typedef enum logic [1:0] {SLOT_NORMAL, SLOT_SECOND, SLOT_FLUSH} bidc_slot_e;
  typedef enum logic {ALU_DEC, ALU_DAW} bidc_aluop_e;
endpackage

/* File: rtl/bidc_alu.sv */
/*
  Arithmetic for the decrement-file and decimal-adjust operations.
  Purely combinational; the core registers every result it keeps.
*/
`timescale 1ns/1ps
module bidc_alu
  import bidc_pkg::*;
(
  input  wire bidc_pkg::bidc_aluop_e op_i,
  input  wire logic [7:0]            a_i,
  input  wire logic                  c_i,
  input  wire logic                  dc_i,
  output logic [7:0]                 res_o,
  output logic                       c_o,
  output logic                       dc_o,
  output logic                       n_o,
  output logic                       ov_o,
  output logic                       z_o
);
  logic [8:0] lo_sum;
  logic [8:0] hi_sum;
  logic       lo_fix;
  logic       hi_fix;

  always_comb begin
    lo_fix = (a_i[3:0] > 4'h9) || dc_i;
    lo_sum = {1'b0, a_i} + (lo_fix ? 9'h006 : 9'h000);
    hi_fix = (lo_sum[7:4] > 4'h9) || c_i || lo_sum[8];
    hi_sum = {1'b0, lo_sum[7:0]} + (hi_fix ? 9'h060 : 9'h000);
    if (op_i == ALU_DAW) begin
      res_o = hi_sum[7:0];
      c_o   = hi_sum[8] | lo_sum[8] | c_i;
      dc_o  = dc_i;
      ov_o  = 1'b0;
    end else begin
      res_o = a_i - 8'h01;
      c_o   = (a_i != 8'h00);
      dc_o  = (a_i[3:0] != 4'h0);
      ov_o  = (a_i == 8'h80);
    end
    n_o = res_o[7];
    z_o = (res_o == 8'h00);
  end
endmodule

/* File: rtl/bidc_core.sv */
/*
  Byte instruction decode core: fetches 16-bit words, decodes byte, bit,
  literal and control instructions and runs them on a four-quarter cycle.
  Assumes program memory answers prog_addr_o by quarter Q4 and data memory
  returns read data one clock after data_rd_o.
*/
// Chosen here: the address-and-strobe port and the address map.
// Summary of operation
// - Instructions are fetched as 16-bit words with opcode and operand fields
// - Exactly three instructions use two words; all others use one
// - Byte operations carry file number, destination select and access select
// - Destination zero writes working register; one writes the file register
// - Bit operations pick one bit of the addressed file register
// - Literal operations carry a constant and optionally a pointer select
// - Control operations decode address, call/return mode and table mode
// - Second word of a double-word instruction has top four bits set
// - A second word executed alone behaves as no-operation
// - One cycle per single word; taken test or jump adds a NOP cycle
// - Double-word instructions take two cycles; taken branches take three
// - Each instruction cycle spans four clock periods
// - Decimal adjust adds six to low nibble above nine or digit carry
// - Decimal adjust adds six to high nibble above nine or carry
// - Decrement file subtracts one and writes per destination select
`timescale 1ns/1ps
module bidc_core
  import bidc_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         ce_i,
  output logic [bidc_pkg::PC_W-1:0]         prog_addr_o,
  input  wire logic [15:0]                  prog_data_i,
  output logic [bidc_pkg::DADDR_W-1:0]      data_addr_o,
  output logic                              data_rd_o,
  output logic                              data_wr_o,
  output logic [7:0]                        data_wdata_o,
  input  wire logic [7:0]                   data_rdata_i,
  output logic                              tbl_req_o,
  output logic                              tbl_write_o,
  output logic [1:0]                        tbl_mode_o,
  output logic [1:0]                        quarter_o,
  input  wire logic [bidc_pkg::BUS_AW-1:0]  reg_addr_i,
  input  wire logic [31:0]                  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic [31:0]                       reg_rdata_o
);
  import bidc_pkg::*;

  logic [1:0]                quarter;
  logic [1:0]                next_quarter;
  bidc_slot_e                slot;
  bidc_slot_e                next_slot;
  logic [15:0]               ir;
  logic [15:0]               next_ir;
  logic [15:0]               first_word;
  logic [15:0]               next_first_word;
  logic [PC_W-1:0]           pc;
  logic [PC_W-1:0]           next_pc;
  logic [PC_W-1:0]           ret_pc;
  logic [PC_W-1:0]           next_ret_pc;
  logic [7:0]                working_register;
  logic [7:0]                next_working_register;
  logic [7:0]                working_register_shadow;
  logic [7:0]                next_working_register_shadow;
  logic [4:0]                flags;
  logic [4:0]                next_flags;
  logic [4:0]                flags_shadow;
  logic [4:0]                next_flags_shadow;
  logic [3:0]                bank;
  logic [3:0]                next_bank;
  logic [3:0]                bank_shadow;
  logic [3:0]                next_bank_shadow;
  logic [PTR_N-1:0][PTR_W-1:0] ptr;
  logic [PTR_N-1:0][PTR_W-1:0] next_ptr;
  logic                      run;
  logic                      next_run;
  logic                      step;
  logic                      next_step;
  logic [31:0]               cycles;
  logic [31:0]               next_cycles;
  logic [DADDR_W-1:0]        next_data_addr;
  logic                      next_data_rd;
  logic                      next_data_wr;
  logic [7:0]                next_data_wdata;
  logic                      next_tbl_req;
  logic                      next_tbl_write;
  logic [1:0]                next_tbl_mode;
  logic [31:0]               next_rdata;

  // Decode of the word in the instruction register and of the saved first word
  logic              is_daw;
  logic              is_dec;
  logic              is_ret;
  logic              is_tbl;
  logic              is_movl;
  logic              is_bset;
  logic              is_bclr;
  logic              is_btst;
  logic              is_goto;
  logic              is_call;
  logic              is_lptr;
  logic              is_two;
  logic              need_file;
  logic              second_ok;
  logic [7:0]        bit_mask;
  logic [DADDR_W-1:0] file_addr;
  logic [1:0]        ptr_sel;
  logic              running;

  assign is_daw    = (ir == OP_DAW);
  assign is_dec    = (ir[15:10] == OP_DEC6);
  assign is_ret    = (ir[15:1] == OP_RET15);
  assign is_tbl    = (ir[15:3] == OP_TBL13);
  assign is_movl   = (ir[15:8] == OP_MOVL8);
  assign is_bset   = (ir[15:12] == OP_BSET4);
  assign is_bclr   = (ir[15:12] == OP_BCLR4);
  assign is_btst   = (ir[15:12] == OP_BTST4);
  assign is_goto   = (first_word[15:8] == OP_GOTO8);
  assign is_call   = (first_word[15:9] == OP_CALL7);
  assign is_lptr   = (first_word[15:6] == OP_LPTR10);
  assign is_two    = (ir[15:8] == OP_GOTO8) || (ir[15:9] == OP_CALL7)
                   || (ir[15:6] == OP_LPTR10);
  assign need_file = is_dec | is_bset | is_bclr | is_btst;
  assign second_ok = (ir[15:12] == SECOND_NIB);
  assign bit_mask  = 8'h01 << ir[F_B_LO +: 3];
  // Access select zero ignores the bank select register
  assign file_addr = {ir[F_A] ? bank : ACCESS_BANK, ir[7:0]};
  assign ptr_sel   = first_word[5:4];
  assign running   = run | step;

  bidc_aluop_e alu_op;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_dc;
  logic        alu_n;
  logic        alu_ov;
  logic        alu_z;

  assign alu_op = is_daw ? ALU_DAW : ALU_DEC;

  bidc_alu u_alu (
    .op_i  (alu_op),
    .a_i   (is_daw ? working_register : data_rdata_i),
    .c_i   (flags[ST_C]),
    .dc_i  (flags[ST_DC]),
    .res_o (alu_res),
    .c_o   (alu_c),
    .dc_o  (alu_dc),
    .n_o   (alu_n),
    .ov_o  (alu_ov),
    .z_o   (alu_z)
  );

  always_comb begin
    next_quarter      = quarter;
    next_slot         = slot;
    next_ir           = ir;
    next_first_word   = first_word;
    next_pc           = pc;
    next_ret_pc       = ret_pc;
    next_working_register         = working_register;
    next_working_register_shadow  = working_register_shadow;
    next_flags        = flags;
    next_flags_shadow = flags_shadow;
    next_bank         = bank;
    next_bank_shadow  = bank_shadow;
    next_ptr          = ptr;
    next_run          = run;
    next_step         = step;
    next_cycles       = cycles;
    next_data_addr    = data_addr_o;
    next_data_rd      = 1'b0;
    next_data_wr      = 1'b0;
    next_data_wdata   = data_wdata_o;
    next_tbl_req      = 1'b0;
    next_tbl_write    = tbl_write_o;
    next_tbl_mode     = tbl_mode_o;
    next_rdata        = 32'h0000_0000;

    if (running) begin
      next_quarter = quarter + Q_STEP;
      if (quarter == Q_READ && slot == SLOT_NORMAL && need_file) begin
        next_data_rd   = 1'b1;
        next_data_addr = file_addr;
      end
      if (quarter == Q_LAST) begin
        // Fetch the following word as this cycle ends
        next_ir     = prog_data_i;
        next_pc     = pc + 20'h00001;
        next_slot   = SLOT_NORMAL;
        next_cycles = cycles + 32'h0000_0001;
        next_step   = 1'b0;
        unique case (slot)
          // Unlisted words, a lone second word among them, run as NOP
          SLOT_NORMAL: begin
            if (is_daw) begin
              next_working_register        = alu_res;
              next_flags[ST_C] = alu_c;
            end else if (is_dec) begin
              if (ir[F_D]) begin
                next_data_wr    = 1'b1;
                next_data_wdata = alu_res;
              end else begin
                next_working_register = alu_res;
              end
              next_flags = {alu_n, alu_ov, alu_z, alu_dc, alu_c};
            end else if (is_bset || is_bclr) begin
              next_data_wr    = 1'b1;
              next_data_wdata = is_bset ? (data_rdata_i | bit_mask)
                                        : (data_rdata_i & ~bit_mask);
            end else if (is_btst) begin
              // A true test discards the next word as a NOP cycle
              if ((data_rdata_i & bit_mask) != 8'h00) begin
                next_slot = SLOT_FLUSH;
              end
            end else if (is_movl) begin
              next_working_register = ir[7:0];
            end else if (is_ret) begin
              next_pc   = ret_pc;
              next_slot = SLOT_FLUSH;
              if (ir[F_S]) begin
                next_working_register  = working_register_shadow;
                next_flags = flags_shadow;
                next_bank  = bank_shadow;
              end
            end else if (is_tbl) begin
              next_tbl_req   = 1'b1;
              next_tbl_mode  = ir[1:0];
              next_tbl_write = ir[F_TBLWR];
            end else if (is_two) begin
              next_first_word = ir;
              next_slot       = SLOT_SECOND;
            end
          end
          SLOT_SECOND: begin
            // A malformed second word makes the pair a NOP
            if (second_ok) begin
              if (is_goto || is_call) begin
                next_pc   = {first_word[7:0], ir[11:0]};
                next_slot = SLOT_FLUSH;
                if (is_call) begin
                  next_ret_pc = pc;
                  if (first_word[F_CALLS]) begin
                    next_working_register_shadow  = working_register;
                    next_flags_shadow = flags;
                    next_bank_shadow  = bank;
                  end
                end
              end else if (is_lptr && ptr_sel != 2'h3) begin
                next_ptr[ptr_sel] = {first_word[3:0], ir[7:0]};
              end
            end
          end
          // Word fetched behind a jump or true test runs as a NOP
          SLOT_FLUSH: begin
          end
        endcase
      end
    end

    // Software register writes take effect after the core's own update
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          next_run  = reg_wdata_i[CTL_RUN];
          next_step = reg_wdata_i[CTL_STEP];
        end
        REG_WORK:   next_working_register  = reg_wdata_i[7:0];
        REG_STATUS: next_flags = reg_wdata_i[4:0];
        REG_BANK:   next_bank  = reg_wdata_i[3:0];
        default: begin
        end
      endcase
    end

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL:   next_rdata = {30'h0, step, run};
        REG_WORK:   next_rdata = {24'h0, working_register};
        REG_STATUS: next_rdata = {27'h0, flags};
        REG_BANK:   next_rdata = {28'h0, bank};
        REG_PC:     next_rdata = {12'h0, pc};
        REG_PTR0:   next_rdata = {20'h0, ptr[0]};
        REG_PTR1:   next_rdata = {20'h0, ptr[1]};
        REG_PTR2:   next_rdata = {20'h0, ptr[2]};
        REG_RETPC:  next_rdata = {12'h0, ret_pc};
        REG_CYCLES: next_rdata = cycles;
        REG_INSTR:  next_rdata = {12'h0, slot, quarter, ir};
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      quarter      <= Q_DECODE;
      slot         <= SLOT_NORMAL;
      ir           <= IR_RST;
      first_word   <= IR_RST;
      pc           <= PC_RST;
      ret_pc       <= PC_RST;
      working_register         <= 8'h00;
      working_register_shadow  <= 8'h00;
      flags        <= 5'h00;
      flags_shadow <= 5'h00;
      bank         <= 4'h0;
      bank_shadow  <= 4'h0;
      ptr          <= '0;
      run          <= RUN_RST;
      step         <= 1'b0;
      cycles       <= 32'h0000_0000;
      data_addr_o  <= 12'h000;
      data_rd_o    <= 1'b0;
      data_wr_o    <= 1'b0;
      data_wdata_o <= 8'h00;
      tbl_req_o    <= 1'b0;
      tbl_write_o  <= 1'b0;
      tbl_mode_o   <= 2'h0;
      reg_rdata_o  <= 32'h0000_0000;
    end else if (ce_i) begin
      quarter      <= next_quarter;
      slot         <= next_slot;
      ir           <= next_ir;
      first_word   <= next_first_word;
      pc           <= next_pc;
      ret_pc       <= next_ret_pc;
      working_register         <= next_working_register;
      working_register_shadow  <= next_working_register_shadow;
      flags        <= next_flags;
      flags_shadow <= next_flags_shadow;
      bank         <= next_bank;
      bank_shadow  <= next_bank_shadow;
      ptr          <= next_ptr;
      run          <= next_run;
      step         <= next_step;
      cycles       <= next_cycles;
      data_addr_o  <= next_data_addr;
      data_rd_o    <= next_data_rd;
      data_wr_o    <= next_data_wr;
      data_wdata_o <= next_data_wdata;
      tbl_req_o    <= next_tbl_req;
      tbl_write_o  <= next_tbl_write;
      tbl_mode_o   <= next_tbl_mode;
      reg_rdata_o  <= next_rdata;
    end
  end

  assign prog_addr_o = pc;
  assign quarter_o   = quarter;
endmodule

/* File: tb/bidc_core_chk.sv */
/*
  Concurrent checks on the quarter timing and data memory strobes of the
  decode core. Assumes one clock domain and ce_i high while the core runs.
*/
`timescale 1ns/1ps
module bidc_core_chk
  import bidc_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [1:0]               quarter_o,
  input  wire logic [bidc_pkg::PC_W-1:0] prog_addr_o,
  input  wire logic                     data_rd_o,
  input  wire logic                     data_wr_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_cycle_start;
    $past(quarter_o) == Q_DECODE && quarter_o == Q_READ;
  endsequence
  sequence s_cycle_tail;
    quarter_o == 2'h2 ##1 quarter_o == Q_LAST ##1 quarter_o == Q_DECODE;
  endsequence

  property p_quarter_step;
    1'b1 |=> (quarter_o == $past(quarter_o) || quarter_o == $past(quarter_o) + 2'h1);
  endproperty
  property p_cycle_span;
    s_cycle_start |=> s_cycle_tail;
  endproperty
  property p_rd_slot;
    data_rd_o |-> quarter_o == 2'h2;
  endproperty
  property p_rd_pulse;
    data_rd_o |=> !data_rd_o;
  endproperty
  property p_wr_slot;
    data_wr_o |-> quarter_o == Q_DECODE;
  endproperty
  property p_wr_pulse;
    data_wr_o |=> !data_wr_o;
  endproperty
  property p_wr_after_rd;
    data_wr_o |-> ($past(data_rd_o, 2) || $past(data_rd_o, 3));
  endproperty
  property p_pc_hold;
    quarter_o != Q_DECODE |-> $stable(prog_addr_o);
  endproperty

  a_quarter_step: assert property (p_quarter_step)
    else $error("quarter counter skipped a value");
  a_cycle_span: assert property (p_cycle_span)
    else $error("instruction cycle is not four clocks");
  a_rd_slot: assert property (p_rd_slot)
    else $error("file read outside quarter two");
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("file read strobe longer than one clock");
  a_wr_slot: assert property (p_wr_slot)
    else $error("file write outside quarter zero");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("file write strobe longer than one clock");
  a_wr_after_rd: assert property (p_wr_after_rd)
    else $error("file write without a preceding read");
  a_pc_hold: assert property (p_pc_hold)
    else $error("fetch address moved inside an instruction cycle");
endmodule

bind bidc_core bidc_core_chk bidc_core_chk_inst (
  .core_clk_i  (core_clk_i),
  .rst_n_i     (rst_n_i),
  .quarter_o   (quarter_o),
  .prog_addr_o (prog_addr_o),
  .data_rd_o   (data_rd_o),
  .data_wr_o   (data_wr_o)
);

/* File: tb/bidc_mem_model.sv */
/*
  Program and file memory seen by the decode core. The bench loads both
  arrays by hierarchy; read data is only valid the clock after a read.
*/
`timescale 1ns/1ps
module bidc_mem_model
  import bidc_pkg::*;
(
  input  wire logic                        core_clk_i,
  input  wire logic [bidc_pkg::PC_W-1:0]    prog_addr_i,
  output logic [15:0]                      prog_data_o,
  input  wire logic [bidc_pkg::DADDR_W-1:0] data_addr_i,
  input  wire logic                        data_rd_i,
  input  wire logic                        data_wr_i,
  input  wire logic [7:0]                  data_wdata_i,
  output logic [7:0]                       data_rdata_o
);
  logic [15:0] prog [0:63];
  logic [7:0]  dmem [0:4095];
  logic [7:0]  rd_q;
  logic        rd_vld;

  // Words beyond the loaded area read as no-operation
  assign prog_data_o = (prog_addr_i < 64) ? prog[prog_addr_i[5:0]] : 16'h0000;
  // Outside the answer slot the bus shows the inverse of the last byte
  assign data_rdata_o = rd_vld ? rd_q : ~rd_q;

  initial begin
    rd_q = 8'h00;
    rd_vld = 1'b0;
  end

  always @(posedge core_clk_i) begin
    rd_vld <= data_rd_i;
    if (data_rd_i) begin
      rd_q <= dmem[data_addr_i];
    end
    if (data_wr_i) begin
      dmem[data_addr_i] <= data_wdata_i;
    end
  end
endmodule

/* File: tb/testbench.sv */
/*
  Self-checking bench for the decode core: runs short programs from the
  memory model and compares registers and file memory with expectations.
  Assumes ce_i high except in the freeze check, and the package offsets.
*/
`timescale 1ns/1ps
module testbench;
  import bidc_pkg::*;
  logic                core_clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                ce_i = 1'b1;
  logic [PC_W-1:0]     prog_addr_o;
  logic [15:0]         prog_data_i;
  logic [DADDR_W-1:0]  data_addr_o;
  logic                data_rd_o;
  logic                data_wr_o;
  logic [7:0]          data_wdata_o;
  logic [7:0]          data_rdata_i;
  logic [BUS_AW-1:0]   reg_addr_i = 8'h00;
  logic [31:0]         reg_wdata_i = 32'h0;
  logic                reg_wr_i = 1'b0;
  logic                reg_rd_i = 1'b0;
  logic [31:0]         reg_rdata_o;
  int                  n_fail = 0;
  int                  checks = 0;
  logic [31:0]         r;
  logic [8:0]          dw;
  logic [7:0]          w, v, f, nv;
  logic [4:0]          st;
  logic [3:0]          bank;
  logic [11:0]         adr, alt;
  logic                c, dc, d, a, set;
  logic                tw;
  logic [1:0]          tm;

  always #4 core_clk_i = ~core_clk_i;

  bidc_core bidc_core_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .data_addr_o(data_addr_o),
    .data_rd_o(data_rd_o), .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o),
    .data_rdata_i(data_rdata_i), .tbl_req_o(), .tbl_write_o(tw), .tbl_mode_o(tm),
    .quarter_o(), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  bidc_mem_model bidc_mem_model_inst (.core_clk_i(core_clk_i), .prog_addr_i(prog_addr_o),
    .prog_data_o(prog_data_i), .data_addr_i(data_addr_o), .data_rd_i(data_rd_o),
    .data_wr_i(data_wr_o), .data_wdata_i(data_wdata_o), .data_rdata_o(data_rdata_i));

  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] ad, input logic [31:0] dat);
    @(posedge core_clk_i);
    reg_addr_i <= ad;
    reg_wdata_i <= dat;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] ad, output logic [31:0] dat);
    @(posedge core_clk_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 dat = reg_rdata_o;
  endtask

  // Short reset and an all-NOP program before each scenario
  task automatic restart();
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 64; i++) bidc_mem_model_inst.prog[i] = 16'h0000;
  endtask

  // Runs until the fetch address reaches tgt, then stops at a cycle boundary
  task automatic go(input int tgt);
    logic [31:0] pc;
    int k;
    bus_wr(REG_CTRL, 32'h1);
    for (k = 0; k < 100; k++) begin
      bus_rd(REG_PC, pc);
      if (pc >= tgt) break;
    end
    if (k == 100) begin
      n_fail++;
      close_out();
    end
    repeat (8) @(posedge core_clk_i);
    #1;
    for (k = 0; k < 8 && bidc_core_inst.quarter_o !== 2'h2; k++) @(posedge core_clk_i) #1;
    if (k == 8) begin
      n_fail++;
      close_out();
    end
    bus_wr(REG_CTRL, 32'h0);
  endtask

  function automatic logic [8:0] f_daw(input logic [7:0] x, input logic ci, input logic dci);
    logic [8:0] t;
    t = {1'b0, x};
    if (x[3:0] > 4'h9 || dci) t = t + 9'h006;
    if (t[7:4] > 4'h9 || ci || t[8]) t = t + 9'h060;
    return {t[8] | ci, t[7:0]};
  endfunction

  function automatic logic [4:0] f_dec_st(input logic [7:0] x);
    logic [4:0] s;
    logic [7:0] y;
    y = x - 8'h01;
    s = 5'h00;
    s[ST_C] = x != 8'h00;
    s[ST_DC] = x[3:0] != 4'h0;
    s[ST_Z] = y == 8'h00;
    s[ST_OV] = x == 8'h80;
    s[ST_N] = y[7];
    return s;
  endfunction

  initial begin
    void'($urandom(32'hA66C));
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    bus_rd(REG_PC, r);
    check(r, 32'h0);
    bus_rd(8'hFC, r);
    check(r, 32'h0);
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 8'hA5 : (i == 1) ? 8'hCE : 8'($urandom);
      st = (i < 2) ? 5'h00 : 5'($urandom);
      c = st[ST_C];
      dc = st[ST_DC];
      restart();
      bidc_mem_model_inst.prog[0] = {8'h0E, w};
      bidc_mem_model_inst.prog[1] = {SECOND_NIB, 12'hA5A};
      bidc_mem_model_inst.prog[2] = OP_DAW;
      bus_wr(REG_STATUS, {27'h0, st});
      go(4);
      dw = f_daw(w, c, dc);
      bus_rd(REG_WORK, r);
      check(r, {24'h0, dw[7:0]});
      st[ST_C] = dw[8];
      bus_rd(REG_STATUS, r);
      check(r, {27'h0, st});
    end
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : (i == 2) ? 8'h80 : 8'($urandom);
      f = 8'($urandom);
      d = i[0];
      a = i[1];
      bank = 4'(1 + $urandom % 15);
      adr = a ? {bank, f} : {ACCESS_BANK, f};
      alt = a ? {ACCESS_BANK, f} : {bank, f};
      restart();
      bidc_mem_model_inst.dmem[adr] = v;
      bidc_mem_model_inst.dmem[alt] = v ^ 8'h5A;
      bidc_mem_model_inst.prog[0] = {OP_DEC6, d, a, f};
      bus_wr(REG_BANK, {28'h0, bank});
      bus_wr(REG_WORK, 32'h3C);
      go(3);
      bus_rd(REG_WORK, r);
      check(r, d ? 32'h3C : {24'h0, v - 8'h01});
      check({24'h0, bidc_mem_model_inst.dmem[adr]}, {24'h0, d ? v - 8'h01 : v});
      bus_rd(REG_STATUS, r);
      check(r, {27'h0, f_dec_st(v)});
    end
    for (int i = 0; i < 8; i++) begin
      f = 8'($urandom);
      v = 8'($urandom);
      set = 1'($urandom);
      nv = set ? (v | (8'h01 << i)) : (v & ~(8'h01 << i));
      restart();
      bidc_mem_model_inst.dmem[{ACCESS_BANK, f}] = v;
      bidc_mem_model_inst.prog[0] = {set ? OP_BSET4 : OP_BCLR4, 3'(i), 1'b0, f};
      bidc_mem_model_inst.prog[1] = {OP_BTST4, 3'(i), 1'b0, f};
      bidc_mem_model_inst.prog[2] = {8'h0E, 8'h11};
      bus_wr(REG_WORK, 32'h99);
      go(4);
      check({24'h0, bidc_mem_model_inst.dmem[{ACCESS_BANK, f}]}, {24'h0, nv});
      bus_rd(REG_WORK, r);
      check(r, set ? 32'h99 : 32'h11);
    end
    restart();
    bidc_mem_model_inst.prog[0] = {OP_GOTO8, 8'h00};
    bidc_mem_model_inst.prog[1] = {SECOND_NIB, 12'h006};
    bidc_mem_model_inst.prog[2] = {8'h0E, 8'h11};
    bidc_mem_model_inst.prog[6] = {8'h0E, 8'h33};
    bidc_mem_model_inst.prog[7] = {OP_LPTR10, 2'h1, 4'hA};
    bidc_mem_model_inst.prog[8] = {SECOND_NIB, 4'h0, 8'h5C};
    bidc_mem_model_inst.prog[9] = {OP_TBL13, 1'b1, 2'h2};
    go(12);
    bus_rd(REG_WORK, r);
    check(r, 32'h33);
    bus_rd(REG_PTR1, r);
    check(r, 32'hA5C);
    check({29'h0, tw, tm}, 32'h6);
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    bus_wr(REG_WORK, 32'h5A);
    ce_i <= 1'b1;
    bus_rd(REG_WORK, r);
    check(r, 32'h33);
    close_out();
  end
endmodule
